// ==== nlbg_top.sv ====
`timescale 1ns/100ps
module nlbg_top #(
    parameter int HALF_CYC = nlbg_pkg::BIT_HALF_CYC
) (
    // Clock and synchronous reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins from outside the clock domain.
    input wire logic en_pin,
    input wire logic start_input,
    // Word memory write from the host side logic.
    input wire logic cfg_wr_valid,
    input wire logic [2:0] cfg_wr_addr,
    input wire logic [7:0] cfg_wr_data,
    output logic cfg_wr_ready,
    // Length preload from the host side logic.
    input wire logic len_wr,
    input wire logic [6:0] len_data,
    // Serial link and status.
    output logic ser_clk,
    output logic ser_data,
    output logic [7:0] cur_state
);
    localparam int SW = nlbg_pkg::SEL_W;
    localparam int LW = nlbg_pkg::LEN_W;
    localparam int WW = nlbg_pkg::WORD_W;

    // Two-flop synchronisers for the pins; only the second flop is read.
    logic en_m, en_s, start_m, start_s;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            en_m <= 1'b0;
            en_s <= 1'b0;
            start_m <= 1'b0;
            start_s <= 1'b0;
        end else begin
            en_m <= en_pin;
            en_s <= en_m;
            start_m <= start_input;
            start_s <= start_m;
        end
    end

    function automatic logic [2:0] st_idx(input nlbg_pkg::nlbg_state_t s);
        unique case (s)
            nlbg_pkg::ST0: st_idx = 3'h0;
            nlbg_pkg::ST1: st_idx = 3'h1;
            nlbg_pkg::ST2: st_idx = 3'h2;
            nlbg_pkg::ST3: st_idx = 3'h3;
            nlbg_pkg::ST4: st_idx = 3'h4;
            nlbg_pkg::ST5: st_idx = 3'h5;
            nlbg_pkg::ST6: st_idx = 3'h6;
            nlbg_pkg::ST7: st_idx = 3'h7;
        endcase
    endfunction

    // Fixed series order, last state wraps to the first.
    function automatic nlbg_pkg::nlbg_state_t st_next(input nlbg_pkg::nlbg_state_t s);
        unique case (s)
            nlbg_pkg::ST0: st_next = nlbg_pkg::ST1;
            nlbg_pkg::ST1: st_next = nlbg_pkg::ST2;
            nlbg_pkg::ST2: st_next = nlbg_pkg::ST3;
            nlbg_pkg::ST3: st_next = nlbg_pkg::ST4;
            nlbg_pkg::ST4: st_next = nlbg_pkg::ST5;
            nlbg_pkg::ST5: st_next = nlbg_pkg::ST6;
            nlbg_pkg::ST6: st_next = nlbg_pkg::ST7;
            nlbg_pkg::ST7: st_next = nlbg_pkg::ST0;
        endcase
    endfunction

    // A zero length would wrap the 7-bit counter and run 128 bits, so it is raised to one bit.
    function automatic logic [LW-1:0] len_clamp(input logic [LW-1:0] v);
        if (v > nlbg_pkg::MAX_LEN) begin
            len_clamp = nlbg_pkg::MAX_LEN;
        end else if (v == '0) begin
            len_clamp = 7'h01;
        end else begin
            len_clamp = v;
        end
    endfunction

    localparam int HALF_W_L = nlbg_pkg::HALF_W;
    nlbg_pkg::nlbg_state_t st_q, st_d;
    logic [HALF_W_L-1:0] half_q, half_d;
    logic [SW-1:0] sel_q, sel_d;
    logic [LW-1:0] len_q, len_d, lcnt_q, lcnt_d;
    logic sclk_q, sclk_d, data_q, data_d, stepclk_q, stepclk_d;
    logic started_q, started_d;
    logic bit_ev, step_ev;
    logic [WW-1:0] mem_q [nlbg_pkg::STATES];
    logic [WW-1:0] mem_d [nlbg_pkg::STATES];
    logic drain_valid, drain_ready;
    logic [10:0] drain_word;
    logic [WW-1:0] next_word;

    // Host writes pass a two-entry buffer; the memory only takes them while
    // the link is idle or at a word boundary, so a word is only torn if the link is disabled mid-shift.
    nlbg_buf #(.W(11), .DEPTH(nlbg_pkg::BUF_DEPTH)) u_buf (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(cfg_wr_valid),
        .in_data({cfg_wr_addr, cfg_wr_data}),
        .in_ready(cfg_wr_ready),
        .out_valid(drain_valid),
        .out_data(drain_word),
        .out_ready(drain_ready)
    );
    assign drain_ready = !en_s || step_ev;

    // Word memory next value; reset holds the counter pattern.
    always_comb begin
        for (int i = 0; i < nlbg_pkg::STATES; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (drain_valid && drain_ready) begin
            mem_d[drain_word[10:8]] = drain_word[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < nlbg_pkg::STATES; i++) begin
            if (sys_rst) begin
                mem_q[i] <= WW'(i);
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    // Serial clock divider, bit select, length counter and sequencer.
    always_comb begin
        half_d = half_q;
        sclk_d = sclk_q;
        sel_d = sel_q;
        st_d = st_q;
        stepclk_d = stepclk_q;
        lcnt_d = lcnt_q;
        started_d = started_q;
        bit_ev = 1'b0;
        step_ev = 1'b0;
        len_d = len_wr ? len_clamp(len_data) : len_q;
        if (!started_q && start_s && st_q == nlbg_pkg::ST0) begin
            st_d = nlbg_pkg::ST1;
            started_d = 1'b1;
        end
        if (!en_s) begin
            half_d = '0;
            sclk_d = 1'b0;
        end else if (half_q == HALF_W_L'(HALF_CYC - 1)) begin
            half_d = '0;
            sclk_d = !sclk_q;
            bit_ev = sclk_q && started_q;
        end else begin
            half_d = HALF_W_L'(half_q + 1'b1);
        end
        // Bits change on the falling edge so the far side samples on rising.
        if (bit_ev) begin
            if (lcnt_q == 7'h01) begin
                lcnt_d = len_q;
                sel_d = nlbg_pkg::SEL_FIRST;
                st_d = nlbg_pkg::ST1;
                step_ev = 1'b1;
            end else begin
                lcnt_d = LW'(lcnt_q - 1'b1);
                if (sel_q == '0) begin
                    sel_d = nlbg_pkg::SEL_FIRST;
                    st_d = st_next(st_q);
                    step_ev = 1'b1;
                end else begin
                    sel_d = SW'(sel_q - 1'b1);
                end
            end
        end
        // One step event is a single cycle, so one transition per pulse.
        if (step_ev) begin
            stepclk_d = !stepclk_q;
        end
    end

    // Mux the selected bit; idle shows the word's MSB.
    always_comb begin
        next_word = mem_d[st_idx(st_d)];
        if (!en_s) begin
            data_d = next_word[WW-1];
        end else begin
            data_d = next_word[sel_d];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= nlbg_pkg::ST0;
            half_q <= '0;
            sclk_q <= 1'b0;
            sel_q <= nlbg_pkg::SEL_FIRST;
            len_q <= nlbg_pkg::LEN_RST;
            lcnt_q <= nlbg_pkg::LEN_RST;
            stepclk_q <= 1'b0;
            started_q <= 1'b0;
            data_q <= 1'b0;
        end else begin
            st_q <= st_d;
            half_q <= half_d;
            sclk_q <= sclk_d;
            sel_q <= sel_d;
            len_q <= len_d;
            lcnt_q <= lcnt_d;
            stepclk_q <= stepclk_d;
            started_q <= started_d;
            data_q <= data_d;
        end
    end

    assign ser_clk = sclk_q;
    assign ser_data = data_q;
    assign cur_state = st_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    state_onehot_a: assert property ($onehot(st_q))
        else $error("state not one-hot");
    // The start move itself is no step event, so only moves after it are judged.
    step_only_a: assert property ($past(started_q) && $changed(st_q) |-> $past(step_ev))
        else $error("state moved without step");
    start_leave_a: assert property (!started_q && start_s && st_q == nlbg_pkg::ST0 |=>
        st_q == nlbg_pkg::ST1 && started_q)
        else $error("start did not leave state 0");
    sclk_idle_a: assert property (!en_s |=> !ser_clk)
        else $error("serial clock ran while disabled");
    data_msb_a: assert property (!en_s ##1 !en_s |-> ser_data == mem_q[st_idx(st_q)][WW-1])
        else $error("idle data not word msb");
    sel_step_a: assert property (bit_ev && lcnt_q != 7'h01 && sel_q != '0 |=>
        sel_q == SW'($past(sel_q) - 1'b1) && st_q == $past(st_q))
        else $error("select did not advance by one");
    len_reload_a: assert property (bit_ev && lcnt_q == 7'h01 |=>
        lcnt_q == $past(len_q) && st_q == nlbg_pkg::ST1 && sel_q == nlbg_pkg::SEL_FIRST)
        else $error("length reload failed");
    step_toggle_a: assert property (step_ev |=> stepclk_q != $past(stepclk_q))
        else $error("step clock did not toggle");
    len_range_a: assert property (len_q != '0 && len_q <= nlbg_pkg::MAX_LEN)
        else $error("length out of range");
    mem_write_a: assert property (drain_valid && drain_ready |=>
        mem_q[$past(drain_word[10:8])] == $past(drain_word[7:0]))
        else $error("memory write lost");
    data_mux_a: assert property (en_s && $past(en_s) |-> ser_data ==
        $past(mem_d[st_idx(st_d)][sel_d]))
        else $error("data not selected bit");

    wrap_c: cover property (step_ev && st_q == nlbg_pkg::ST7);
    reload_c: cover property (bit_ev && lcnt_q == 7'h01);
    write_live_c: cover property (en_s && drain_valid && drain_ready);
    full_c: cover property (!cfg_wr_ready);
endmodule // nlbg_top

// ==== nlbg_pkg.sv ====
package nlbg_pkg;
    localparam int STATES = 8;
    localparam int WORD_W = 8;
    localparam int SEL_W = 3;
    localparam int LEN_W = 7;
    localparam logic [LEN_W-1:0] MAX_LEN = 7'h40;
    localparam logic [LEN_W-1:0] LEN_RST = 7'h40;
    localparam logic [SEL_W-1:0] SEL_FIRST = 3'h7;
    localparam int CLK_MHZ = 25;
    localparam int BIT_HALF_NS = 160;
    // Least half period, rounded up to whole cycles.
    localparam int BIT_HALF_CYC = (BIT_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_W = 8;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [7:0] {
        ST0 = 8'h01,
        ST1 = 8'h02,
        ST2 = 8'h04,
        ST3 = 8'h08,
        ST4 = 8'h10,
        ST5 = 8'h20,
        ST6 = 8'h40,
        ST7 = 8'h80
    } nlbg_state_t;
endpackage

// ==== nlbg_buf.sv ====
`timescale 1ns/100ps
module nlbg_buf #(
    parameter int W = 11,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Filling side.
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = AW + 1;

    logic [W-1:0] slot_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // Ready is registered so the port comes straight from a flop; it is
    // computed from the next count so no push is ever lost when full.
    always_comb begin
        push = in_valid && rdy_q;
        pop = out_valid && out_ready;
        wp_d = push ? bump(wp_q) : wp_q;
        rp_d = pop ? bump(rp_q) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = CW'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
        rdy_d = (cnt_d != CW'(DEPTH));
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Storage slots need no reset; they are only read when counted valid.
    always_ff @(posedge mclk) begin
        if (push) begin
            slot_q[wp_q] <= in_data;
        end
    end

    assign in_ready = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = slot_q[rp_q];
endmodule // nlbg_buf

// ==== nlbg_rx.sv ====
`timescale 1ns/100ps
module nlbg_rx (
    // Serial link from the block.
    input wire logic ser_clk,
    input wire logic ser_data,
    // Clears the history.
    input wire logic clr
);
    // Captured bits, oldest first.
    logic hist [0:511];
    int n;

    // Bits are taken on the rising serial clock, away from the falling edge that moves them.
    always @(posedge ser_clk or posedge clr) begin
        if (clr) begin
            n <= 0;
        end else begin
            hist[n[8:0]] <= ser_data;
            n <= n + 1;
        end
    end
endmodule // nlbg_rx

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic mclk, sys_rst, en_pin, start_input, cfg_wr_valid, cfg_wr_ready;
    logic len_wr, ser_clk, ser_data, clr, saw_full, step_on;
    logic [2:0] cfg_wr_addr;
    logic [6:0] len_data;
    logic [7:0] cfg_wr_data, cur_state, prev_state;
    logic [7:0] mem [0:7];
    int total_checks, miscompares, cycles;

    nlbg_top #(.HALF_CYC(4)) i_nlbg_top (.mclk(mclk), .sys_rst(sys_rst),
        .en_pin(en_pin), .start_input(start_input), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data),
        .cfg_wr_ready(cfg_wr_ready), .len_wr(len_wr), .len_data(len_data),
        .ser_clk(ser_clk), .ser_data(ser_data), .cur_state(cur_state));
    nlbg_rx i_nlbg_rx (.ser_clk(ser_clk), .ser_data(ser_data), .clr(clr));

    // A 40 ns clock.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Steps are judged at the clock while step_on is set, so that no state skip goes unseen.
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            summarize();
        end
        if (!sys_rst && step_on && cur_state !== prev_state) begin
            check("step", {prev_state[6:0], prev_state[7]}, cur_state);
        end
        prev_state <= cur_state;
    end

    function automatic logic [7:0] word_at(input int k);
        logic [7:0] w;
        for (int b = 0; b < 8; b++) begin
            w[7-b] = i_nlbg_rx.hist[8*k+b];
        end
        return w;
    endfunction

    function automatic int idx(input logic [7:0] s);
        int r;
        r = 0;
        for (int i = 0; i < 8; i++) begin
            if (s[i] === 1'b1) begin
                r = i;
            end
        end
        return r;
    endfunction

    // A full reset; the memory mirror goes back to word n holding n.
    task automatic restart();
        @(negedge mclk);
        sys_rst = 1'b1;
        clr = 1'b1;
        en_pin = 1'b0;
        start_input = 1'b0;
        step_on = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        clr = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            mem[i] = 8'(i);
        end
    endtask

    // Valid stays up between back-to-back writes; the caller drops it.
    // Ready is read at the falling edge, where it already shows what the next rising edge sees.
    task automatic put_word(input logic [2:0] a, input logic [7:0] d);
        cfg_wr_valid = 1'b1;
        cfg_wr_addr = a;
        cfg_wr_data = d;
        mem[a] = d;
        while (cfg_wr_ready !== 1'b1) begin
            saw_full = 1'b1;
            @(negedge mclk);
        end
        @(negedge mclk);
    endtask

    task automatic wait_bits(input int cnt);
        wait (i_nlbg_rx.n >= cnt);
        @(negedge mclk);
    endtask

    task automatic check_pass(input int k0);
        for (int s = 0; s < 8; s++) begin
            check("word", mem[(s+1)%8], word_at(k0+s));
        end
    endtask

    task automatic test_start();
        restart();
        check("reset state", 8'h01, cur_state);
        check("idle data", 8'h00, {7'h00, ser_data});
        en_pin = 1'b1;
        repeat (40) @(negedge mclk);
        check("no start", 8'h01, cur_state);
        start_input = 1'b1;
        repeat (10) @(negedge mclk);
        check("started", 8'h02, cur_state);
        $display("done start");
    endtask

    task automatic test_stream();
        int rises;
        logic last;
        restart();
        en_pin = 1'b1;
        start_input = 1'b1;
        wait_bits(72);
        check_pass(0);
        check("wrap", mem[1], word_at(8));
        // With a half period of four cycles, sixteen cycles hold two rising edges.
        rises = 0;
        last = ser_clk;
        repeat (16) begin
            @(negedge mclk);
            rises += (ser_clk && !last) ? 1 : 0;
            last = ser_clk;
        end
        check("clk rises", 8'h02, 8'(rises));
        en_pin = 1'b0;
        repeat (8) @(negedge mclk);
        repeat (20) begin
            @(negedge mclk);
            check("clk idle", 8'h00, {7'h00, ser_clk});
            check("msb", {7'h00, mem[idx(cur_state)][7]}, {7'h00, ser_data});
        end
        $display("done stream");
    endtask

    task automatic test_len();
        int ones;
        restart();
        step_on = 1'b0;
        len_data = 7'd12;
        len_wr = 1'b1;
        @(negedge mclk);
        len_wr = 1'b0;
        en_pin = 1'b1;
        start_input = 1'b1;
        wait_bits(140);
        ones = 0;
        for (int i = 104; i < 128; i++) begin
            check("period", {7'h00, i_nlbg_rx.hist[i]}, {7'h00, i_nlbg_rx.hist[i+12]});
            ones += (i < 116) ? int'(i_nlbg_rx.hist[i]) : 0;
        end
        check("ones", 8'h01, 8'(ones));
        $display("done length");
    endtask

    task automatic test_mem();
        int base;
        restart();
        put_word(3'h0, 8'h80);
        cfg_wr_valid = 1'b0;
        repeat (6) @(negedge mclk);
        check("new msb", 8'h01, {7'h00, ser_data});
        en_pin = 1'b1;
        start_input = 1'b1;
        wait_bits(4);
        saw_full = 1'b0;
        put_word(3'h2, 8'hc3);
        put_word(3'h3, 8'h3c);
        put_word(3'h4, 8'hff);
        cfg_wr_valid = 1'b0;
        check("full", 8'h01, {7'h00, saw_full});
        base = (i_nlbg_rx.n / 64 + 2) * 64;
        wait_bits(base + 64);
        check_pass(base / 8);
        $display("done memory");
    endtask

    // Every input has a value from time zero.
    initial begin
        sys_rst = 1'b1;
        clr = 1'b1;
        en_pin = 1'b0;
        start_input = 1'b0;
        cfg_wr_valid = 1'b0;
        cfg_wr_addr = 3'h0;
        cfg_wr_data = 8'h00;
        len_wr = 1'b0;
        len_data = 7'h40;
        step_on = 1'b1;
        saw_full = 1'b0;
        total_checks = 0;
        miscompares = 0;
        cycles = 0;
        test_start();
        test_stream();
        test_len();
        test_mem();
        summarize();
    end
endmodule // tb_top
